// File: vbi_pkg.sv
// Shared constants and types for the data-service status and clock select slice
package vbi_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] ADDR_PAD_CFG = 8'h8F;
  localparam logic [7:0] ADDR_STATUS = 8'h90;
  localparam logic [7:0] ADDR_WSS_LO = 8'h91;
  localparam logic [7:0] ADDR_WSS_HI = 8'h92;
  localparam logic [7:0] ADDR_EDTV_A = 8'h93;
  localparam logic [7:0] ADDR_EDTV_B = 8'h94;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam int SEL_LSB = 4;
  localparam int SEL_W = 3;
  localparam logic [2:0] SEL_FULL = 3'h0;
  localparam logic [2:0] SEL_HALF = 3'h5;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam int BIT_WSS = 0;
  localparam int BIT_CCAP = 1;
  localparam int BIT_EDTV = 2;
  localparam int BIT_CGMS = 3;
  localparam int FLAG_W = 4;
  localparam int WSS_W = 14;
  localparam int WSS_HI_W = 6;
  localparam int EDTV_W = 16;

  // Level outputs of the line decoders plus the copy-control decode event
  typedef struct packed {
    logic widescreen_present;
    logic caption_present;
    logic enhanced_tv_present;
    logic copy_control_present;
    logic copy_control_decode;
    logic copy_control_crc_ok;
  } detect_t;

  typedef struct packed {
    logic [WSS_W-1:0] widescreen;
    logic [EDTV_W-1:0] enhanced_tv;
  } payload_t;
endpackage : vbi_pkg

// File: llc_pad_mux.sv
// Output clock pad selector between full- and half-rate line-locked clocks
`timescale 1ns/1ps
module llc_pad_mux
(
  input wire logic [vbi_pkg::SEL_W-1:0] sel,
  input wire logic line_locked_clock_full_rate,
  input wire logic line_locked_clock_half_rate,
  output logic pad_clk
);
  // Codes other than the half-rate one fall back to full rate
  always_comb
  begin
    if (sel == vbi_pkg::SEL_HALF)
    begin
      pad_clk = line_locked_clock_half_rate;
    end
    else
    begin
      pad_clk = line_locked_clock_full_rate;
    end
  end
endmodule : llc_pad_mux

// File: vbi_status_and_clock_select.sv
// Register slice: output clock pad select, data-service status, payload bytes
`timescale 1ns/1ps
module vbi_status_and_clock_select
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic [vbi_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [vbi_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [vbi_pkg::DATA_W-1:0] REG_RDATA,
  output logic REG_RVALID,
  input wire vbi_pkg::detect_t DETECT,
  input wire logic CGMS_CRC_CHECK_EN,
  input wire logic WSS_VALID,
  input wire logic [vbi_pkg::WSS_W-1:0] WSS_DATA,
  input wire logic EDTV_VALID,
  input wire logic [vbi_pkg::EDTV_W-1:0] EDTV_DATA,
  input wire logic LLC_FULL_RATE,
  input wire logic LLC_HALF_RATE,
  output logic LLC_PAD_OUT,
  output logic [vbi_pkg::SEL_W-1:0] PAD_SELECT
);

  typedef struct packed {
    logic [vbi_pkg::SEL_W-1:0] pad_sel;
    logic [vbi_pkg::FLAG_W-1:0] flags;
    vbi_pkg::payload_t payload;
    logic [vbi_pkg::DATA_W-1:0] rdata;
    logic rvalid;
  } state_t;

  localparam state_t STATE_RESET = '{
    pad_sel: vbi_pkg::SEL_RESET,
    flags: '0,
    payload: '0,
    rdata: '0,
    rvalid: 1'b0
  };

  state_t state_reg;
  state_t state_next;
  logic cgms_accept;
  logic [vbi_pkg::FLAG_W-2:0] level_flags;

  assign level_flags[vbi_pkg::BIT_WSS] = DETECT.widescreen_present;
  assign level_flags[vbi_pkg::BIT_CCAP] = DETECT.caption_present;
  assign level_flags[vbi_pkg::BIT_EDTV] = DETECT.enhanced_tv_present;

  // Decode event qualified by the optional checksum check
  assign cgms_accept = DETECT.copy_control_decode &
    (~CGMS_CRC_CHECK_EN | DETECT.copy_control_crc_ok);

  always_comb
  begin
    state_next = state_reg;
    state_next.rvalid = REG_RD;
    // Only the select field is stored; reserved bits read back as zero
    if (REG_WR && (REG_ADDR == vbi_pkg::ADDR_PAD_CFG))
    begin
      state_next.pad_sel = REG_WDATA[vbi_pkg::SEL_LSB +: vbi_pkg::SEL_W];
    end
    // Presence flags track the decoder levels
    for (int i = 0; i < vbi_pkg::FLAG_W - 1; i++)
    begin
      state_next.flags[i] = level_flags[i];
    end
    // Decode sets, loss of CGMS clears; a set in the same cycle wins
    if (cgms_accept)
    begin
      state_next.flags[vbi_pkg::BIT_CGMS] = 1'b1;
    end
    else if (!DETECT.copy_control_present)
    begin
      state_next.flags[vbi_pkg::BIT_CGMS] = 1'b0;
    end
    // Payload only changes on decoder capture; host writes never reach it
    if (WSS_VALID)
    begin
      state_next.payload.widescreen = WSS_DATA;
    end
    if (EDTV_VALID)
    begin
      state_next.payload.enhanced_tv = EDTV_DATA;
    end
    if (REG_RD)
    begin
      case (REG_ADDR)
        vbi_pkg::ADDR_PAD_CFG:
        begin
          state_next.rdata = '0;
          state_next.rdata[vbi_pkg::SEL_LSB +: vbi_pkg::SEL_W] = state_reg.pad_sel;
        end
        vbi_pkg::ADDR_STATUS:
        begin
          state_next.rdata = {{(vbi_pkg::DATA_W - vbi_pkg::FLAG_W){1'b0}}, state_reg.flags};
        end
        vbi_pkg::ADDR_WSS_LO:
        begin
          state_next.rdata = state_reg.payload.widescreen[vbi_pkg::DATA_W-1:0];
        end
        vbi_pkg::ADDR_WSS_HI:
        begin
          // Undetermined top bits read as zero
          state_next.rdata = {{(vbi_pkg::DATA_W - vbi_pkg::WSS_HI_W){1'b0}},
            state_reg.payload.widescreen[vbi_pkg::WSS_W-1:vbi_pkg::DATA_W]};
        end
        vbi_pkg::ADDR_EDTV_A:
        begin
          state_next.rdata = state_reg.payload.enhanced_tv[vbi_pkg::DATA_W-1:0];
        end
        vbi_pkg::ADDR_EDTV_B:
        begin
          state_next.rdata = state_reg.payload.enhanced_tv[vbi_pkg::EDTV_W-1:vbi_pkg::DATA_W];
        end
        default:
        begin
          state_next.rdata = vbi_pkg::READ_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      state_reg <= STATE_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  llc_pad_mux u_pad_mux
  (
    .sel(state_reg.pad_sel),
    .line_locked_clock_full_rate(LLC_FULL_RATE),
    .line_locked_clock_half_rate(LLC_HALF_RATE),
    .pad_clk(LLC_PAD_OUT)
  );

  assign REG_RDATA = state_reg.rdata;
  assign REG_RVALID = state_reg.rvalid;
  assign PAD_SELECT = state_reg.pad_sel;

  AST_PAD_FULL: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state_reg.pad_sel == vbi_pkg::SEL_FULL) |-> (LLC_PAD_OUT == LLC_FULL_RATE))
    else $error("Full-rate select does not drive full-rate clock");

  AST_PAD_HALF: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (REG_WR && REG_ADDR == vbi_pkg::ADDR_PAD_CFG
      && REG_WDATA[vbi_pkg::SEL_LSB +: vbi_pkg::SEL_W] == vbi_pkg::SEL_HALF)
    |=> (PAD_SELECT == vbi_pkg::SEL_HALF) && (LLC_PAD_OUT == LLC_HALF_RATE))
    else $error("Half-rate write does not select half-rate clock");

  AST_WSS_CCAP_FLAGS: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    ##1 state_reg.flags[vbi_pkg::BIT_WSS] == $past(DETECT.widescreen_present)
      && state_reg.flags[vbi_pkg::BIT_CCAP] == $past(DETECT.caption_present))
    else $error("Wide-screen or caption flag does not follow detection");

  AST_EDTV_FLAG_READ: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (REG_RD && REG_ADDR == vbi_pkg::ADDR_STATUS && !$past(SYS_RST))
    |=> REG_RVALID && REG_RDATA[vbi_pkg::BIT_EDTV] == $past(DETECT.enhanced_tv_present, 2))
    else $error("EDTV flag read does not follow detection");

  AST_EDTV_PAYLOAD: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (EDTV_VALID ##1 (REG_RD && REG_ADDR == vbi_pkg::ADDR_EDTV_A && !EDTV_VALID))
    |=> REG_RVALID && REG_RDATA == $past(EDTV_DATA[vbi_pkg::DATA_W-1:0], 2))
    else $error("EDTV first byte does not return captured data");

  AST_CGMS_LOST: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (!DETECT.copy_control_present && !DETECT.copy_control_decode)
    |=> !state_reg.flags[vbi_pkg::BIT_CGMS])
    else $error("CGMS flag held without CGMS present");

  AST_CGMS_CHECKSUM: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $rose(state_reg.flags[vbi_pkg::BIT_CGMS])
    |-> $past(DETECT.copy_control_decode
      && (!CGMS_CRC_CHECK_EN || DETECT.copy_control_crc_ok)))
    else $error("CGMS flag rose without an accepted packet");

  AST_WSS_READ_ONLY: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (REG_WR && (REG_ADDR == vbi_pkg::ADDR_WSS_LO || REG_ADDR == vbi_pkg::ADDR_WSS_HI)
      && !WSS_VALID) |=> $stable(state_reg.payload.widescreen))
    else $error("Host write changed wide-screen payload");

  AST_WSS_HIGH_BITS: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (REG_RD && REG_ADDR == vbi_pkg::ADDR_WSS_HI)
    |=> REG_RDATA[vbi_pkg::DATA_W-1:vbi_pkg::WSS_HI_W] == '0)
    else $error("Wide-screen high byte top bits not zero");

  // Set wins even when CGMS presence drops in the same cycle
  AST_CGMS_SET: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (DETECT.copy_control_decode && (!CGMS_CRC_CHECK_EN || DETECT.copy_control_crc_ok))
    |=> state_reg.flags[vbi_pkg::BIT_CGMS])
    else $error("Accepted CGMS decode did not set the flag");

  // Every read answered exactly one cycle later, and nothing else
  AST_READ_ANSWER: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    ##1 REG_RVALID == $past(REG_RD))
    else $error("Read answer not exactly one cycle after the request");

  AST_PAD_RESERVED: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (REG_RD && REG_ADDR == vbi_pkg::ADDR_PAD_CFG)
    |=> REG_RDATA[vbi_pkg::SEL_LSB-1:0] == '0 && !REG_RDATA[vbi_pkg::DATA_W-1])
    else $error("Pad select register reserved bits not zero");

  AST_STATUS_TOP_ZERO: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (REG_RD && REG_ADDR == vbi_pkg::ADDR_STATUS)
    |=> REG_RDATA[vbi_pkg::DATA_W-1:vbi_pkg::FLAG_W] == '0)
    else $error("Status register reserved bits not zero");

endmodule : vbi_status_and_clock_select

// File: vbi_status_and_clock_select_tb.sv
// Self-checking testbench for the clock select and data-service status slice
`timescale 1ns/1ps
module vbi_status_and_clock_select_tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  vbi_pkg::detect_t detect = '0;
  logic crc_en = 1'b0;
  logic wss_valid = 1'b0;
  logic [13:0] wss_data = 14'h0000;
  logic edtv_valid = 1'b0;
  logic [15:0] edtv_data = 16'h0000;
  logic llc_full = 1'b1;
  logic llc_half = 1'b0;
  logic llc_pad_out;
  logic [2:0] pad_select;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;

  vbi_status_and_clock_select i_dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst),
    .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .DETECT(detect),
    .CGMS_CRC_CHECK_EN(crc_en), .WSS_VALID(wss_valid), .WSS_DATA(wss_data),
    .EDTV_VALID(edtv_valid), .EDTV_DATA(edtv_data), .LLC_FULL_RATE(llc_full),
    .LLC_HALF_RATE(llc_half), .LLC_PAD_OUT(llc_pad_out), .PAD_SELECT(pad_select));

  always #20 core_clk = ~core_clk;

  // Hang guard, far above the fewer than a hundred cycles the tests need
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge core_clk);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : write_reg

  task automatic read_chk(input logic [7:0] addr, input logic [7:0] exp);
    int n;
    @(negedge core_clk);
    reg_addr = addr;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 3)
    begin
      @(negedge core_clk);
      n++;
    end
    check($sformatf("read of %h", addr), exp, (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX);
  endtask : read_chk

  task automatic pulse_decode(input logic ok);
    @(negedge core_clk);
    detect.copy_control_decode = 1'b1;
    detect.copy_control_crc_ok = ok;
    @(negedge core_clk);
    detect.copy_control_decode = 1'b0;
  endtask : pulse_decode

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    for (int a = 8'h8F; a <= 8'h95; a++)
      read_chk(8'(a), 8'h00);
    check("pad select", 8'h00, {5'h00, pad_select});
    $display("test reset values done");
    llc_full = 1'b0;
    llc_half = 1'b1;
    write_reg(8'h8F, 8'h50);
    check("pad select", 8'h05, {5'h00, pad_select});
    check("pad clock", 8'h01, {7'h00, llc_pad_out});
    read_chk(8'h8F, 8'h50);
    write_reg(8'h8F, 8'h00);
    check("pad clock", 8'h00, {7'h00, llc_pad_out});
    $display("test pad select done");
    for (int i = 0; i < 3; i++)
    begin
      detect = '0;
      detect[5 - i] = 1'b1;
      @(negedge core_clk);
      read_chk(8'h90, 8'h01 << i);
    end
    detect = '0;
    @(negedge core_clk);
    read_chk(8'h90, 8'h00);
    $display("test detect flags done");
    crc_en = 1'b1;
    detect.copy_control_present = 1'b1;
    pulse_decode(1'b0);
    read_chk(8'h90, 8'h00);
    pulse_decode(1'b1);
    read_chk(8'h90, 8'h08);
    detect.copy_control_present = 1'b0;
    @(negedge core_clk);
    read_chk(8'h90, 8'h00);
    crc_en = 1'b0;
    detect.copy_control_present = 1'b1;
    pulse_decode(1'b0);
    read_chk(8'h90, 8'h08);
    // Decode with presence already gone: set for one cycle, then cleared
    detect.copy_control_present = 1'b0;
    pulse_decode(1'b1);
    read_chk(8'h90, 8'h00);
    detect = '0;
    $display("test copy control done");
    @(negedge core_clk);
    wss_data = 14'h3ABC;
    edtv_data = 16'hA55A;
    wss_valid = 1'b1;
    edtv_valid = 1'b1;
    // Read right behind the capture cycle
    fork
      begin
        @(negedge core_clk);
        wss_valid = 1'b0;
        edtv_valid = 1'b0;
      end
      read_chk(8'h93, 8'h5A);
    join
    write_reg(8'h91, 8'hFF);
    write_reg(8'h94, 8'h00);
    read_chk(8'h91, 8'hBC);
    read_chk(8'h92, 8'h3A);
    read_chk(8'h93, 8'h5A);
    read_chk(8'h94, 8'hA5);
    $display("test payloads done");
    complete_run();
  end
endmodule : vbi_status_and_clock_select_tb
